// ===== logic/drive_speed_stop_control.sv
// speed reference, override and stop sequencing for a motor inverter
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Summary of operation
// - four skip bands, disabled ones ignored
// - band spans width below and above centre
// - centre and width limited to max
// - below centre use lower edge, else upper
// - inch runs from preset or analog source
// - inch inhibited while override engaged
// - analog source clamped to min and max
// - override only with building services layout
// - engaged override runs forward, ignores inputs
// - override ignores thermal, retries other trips
// - override enable needs matching access code
// - override survives defaults, blocks industrial layout
// - override stop needs request low, stop
// - timestamp taken when override is enabled
// - timestamp taken when override ignores trip
// - carrier automatic or 2 to 16 khz
// - automatic carrier steps 2 khz on heating
// - stop mode for panel key or run
// - decelerate mode ramps speed to zero
// - freewheel mode stops switching at once
// - injection waits two seconds then dc
// - injection strength 1 to 100 percent
// - injection duration 1 to 60 seconds
// - current-squared-time trip during injection
// - brake switches resistor on regeneration
// - restart attempt ten seconds after trip
// ------------------------------------------------------------------
module drive_speed_stop_control
  import drive_ctrl_pkg::*;
#(
  parameter int SECOND_CYCLES = drive_ctrl_pkg::SECOND_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_nrst,
  // speed configuration
  input  wire drive_ctrl_pkg::speed_limits_type i_limits,
  input  wire drive_ctrl_pkg::skip_band_type [3:0] i_skip,
  input  wire logic [15:0]                i_speed_ref,
  input  wire logic [15:0]                i_analog2,
  input  wire logic [15:0]                i_decel_cycles,
  input  wire logic                       i_reverse,
  // inch
  input  wire logic                       i_inch_close,
  input  wire logic                       i_inch_src_analog,
  input  wire logic [15:0]                i_inch_preset,
  // override and terminal layout
  input  wire logic                       i_override_request,
  input  wire logic                       i_override_enable_req,
  input  wire logic                       i_override_disable_req,
  input  wire logic [15:0]                i_access_code,
  input  wire logic                       i_override_src_analog,
  input  wire logic [15:0]                i_override_preset,
  input  wire logic                       i_layout_req,
  input  wire logic                       i_layout_req_industrial,
  input  wire logic                       i_defaults_restore,
  input  wire logic [31:0]                i_time_now,
  // run controls
  input  wire logic                       i_enable_in,
  input  wire logic                       i_run_in,
  input  wire logic                       i_panel_stop,
  input  wire logic [1:0]                 i_stop_mode,
  input  wire logic [15:0]                i_inj_strength,
  input  wire logic [15:0]                i_inj_duration_s,
  // protection and restart
  input  wire logic                       i_trip_thermal,
  input  wire logic                       i_trip_other,
  input  wire logic                       i_i2t_excess,
  input  wire logic                       i_trip_reset,
  input  wire logic                       i_auto_restart_en,
  // carrier and brake
  input  wire logic                       i_carrier_auto,
  input  wire logic [2:0]                 i_carrier_fixed,
  input  wire logic                       i_heat_rise,
  input  wire logic                       i_heat_fall,
  input  wire logic                       i_brake_fitted,
  input  wire logic                       i_brake_enable,
  input  wire logic                       i_regen,
  // power stage
  output logic [15:0]                     o_speed,
  output logic                            o_forward,
  output logic                            o_switching,
  output logic                            o_inj_active,
  output logic [15:0]                     o_inj_strength,
  output logic [4:0]                      o_carrier_khz,
  output logic                            o_brake_switch,
  // status
  output logic                            o_tripped,
  output logic                            o_override_enabled,
  output logic                            o_override_engaged,
  output logic                            o_layout_building,
  output logic                            o_code_rejected,
  output logic                            o_stressed,
  output logic [31:0]                     o_time_enabled,
  output logic [31:0]                     o_time_stressed
);

  import drive_ctrl_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_RUN    = 6'h02,
    ST_RAMP   = 6'h04,
    ST_DEFLUX = 6'h08,
    ST_INJECT = 6'h10,
    ST_TRIP   = 6'h20
  } state_type;

  function automatic logic [15:0] clamp_val(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end
    if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  state_type   state;
  state_type   next_state;
  state_type   stop_target;
  logic [31:0] cyc;
  logic [5:0]  secs;
  logic [15:0] ramp_cnt;
  logic        ovr_run;
  logic        inch_run;
  logic        stress_q;
  logic [2:0]  carrier_idx;
  logic        engaged;
  logic        stop_cmd;
  logic        start_req;
  logic        inch_ok;
  logic        trip_now;
  logic        stress;
  logic [15:0] sel_speed;
  logic [15:0] next_speed;
  logic [15:0] inj_dur;

  // ------------------------------------------------------------------
  // override qualification
  // ------------------------------------------------------------------
  assign engaged = o_override_enabled && o_layout_building
                   && i_override_request;
  assign inch_ok = i_inch_close && !engaged;
  // enable, run and panel stop are dead while override holds the drive
  assign stop_cmd = i_panel_stop || !i_run_in || !i_enable_in;
  assign start_req = engaged || inch_ok
                     || (i_enable_in && i_run_in && !i_panel_stop);
  // thermal trips are masked only while the override is engaged
  assign trip_now = (i_trip_thermal && !engaged) || i_trip_other
                    || (state == ST_INJECT && i_i2t_excess);
  assign stress = engaged && (i_trip_thermal || i_trip_other)
                  && (state != ST_IDLE);
  assign inj_dur = clamp_val(i_inj_duration_s, INJ_DURATION_MIN,
                             INJ_DURATION_MAX);

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_override_enabled <= 1'b0;
      o_code_rejected    <= 1'b0;
      o_time_enabled     <= 32'h0000_0000;
    end else if (i_override_enable_req) begin
      if (i_access_code == ACCESS_CODE && o_layout_building) begin
        o_override_enabled <= 1'b1;
        o_time_enabled     <= i_time_now;
        o_code_rejected    <= 1'b0;
      end else begin
        o_code_rejected <= 1'b1;
      end
    end else if (i_override_disable_req) begin
      o_override_enabled <= 1'b0;
    end
  end

  // restoring defaults selects building services and keeps the override
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_layout_building <= 1'b1;
    end else if (i_defaults_restore) begin
      o_layout_building <= 1'b1;
    end else if (i_layout_req) begin
      if (!i_layout_req_industrial) begin
        o_layout_building <= 1'b1;
      end else if (!o_override_enabled) begin
        o_layout_building <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stress_q        <= 1'b0;
      o_stressed      <= 1'b0;
      o_time_stressed <= 32'h0000_0000;
    end else begin
      stress_q <= stress;
      if (stress && !stress_q) begin
        o_stressed      <= 1'b1;
        o_time_stressed <= i_time_now;
      end
    end
  end

  // ------------------------------------------------------------------
  // speed reference: source, clamp, then skip bands in order
  // ------------------------------------------------------------------
  always_comb begin
    logic [15:0] src;
    logic [15:0] c;
    logic [15:0] w;
    logic [15:0] lo;
    logic [16:0] hi;
    src = ZERO_SPEED;
    c   = ZERO_SPEED;
    w   = ZERO_SPEED;
    lo  = ZERO_SPEED;
    hi  = 17'h00000;
    if (engaged || ovr_run) begin
      src = i_override_src_analog ? i_analog2 : i_override_preset;
    end else if (inch_run || inch_ok) begin
      src = i_inch_src_analog ? i_analog2 : i_inch_preset;
    end else begin
      src = i_speed_ref;
    end
    sel_speed = clamp_val(src, i_limits.min_freq,
                          i_limits.max_freq);
    for (int k = 0; k < SKIP_COUNT; k++) begin
      if (i_skip[k].enable) begin
        c  = clamp_val(i_skip[k].centre, ZERO_SPEED,
                       i_limits.max_freq);
        w  = clamp_val(i_skip[k].width, ZERO_SPEED,
                       i_limits.max_freq);
        lo = (w > c) ? ZERO_SPEED : 16'(c - w);
        hi = {1'b0, c} + {1'b0, w};
        if (sel_speed >= lo && sel_speed < c) begin
          sel_speed = lo;
        end else if (sel_speed >= c && {1'b0, sel_speed} <= hi) begin
          sel_speed = hi[16] ? 16'hffff : hi[15:0];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // run and stop sequence
  // ------------------------------------------------------------------
  always_comb begin
    unique case (i_stop_mode)
      STOP_FREEWHEEL: stop_target = ST_IDLE;
      STOP_INJECTION: stop_target = ST_DEFLUX;
      default:        stop_target = ST_RAMP;
    endcase
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (trip_now) begin
          next_state = ST_TRIP;
        end else if (start_req) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (trip_now) begin
          next_state = ST_TRIP;
        end else if (engaged) begin
          next_state = ST_RUN;
        end else if (inch_run && !ovr_run) begin
          if (!i_inch_close) begin
            next_state = stop_target;
          end
        end else if (stop_cmd) begin
          next_state = stop_target;
        end
      end
      ST_RAMP: begin
        if (trip_now) begin
          next_state = ST_TRIP;
        end else if (engaged) begin
          next_state = ST_RUN;
        end else if (o_speed == ZERO_SPEED) begin
          next_state = ST_IDLE;
        end
      end
      ST_DEFLUX: begin
        if (trip_now) begin
          next_state = ST_TRIP;
        end else if (engaged) begin
          next_state = ST_RUN;
        end else if (secs == DEFLUX_TIME_S) begin
          next_state = ST_INJECT;
        end
      end
      ST_INJECT: begin
        if (trip_now) begin
          next_state = ST_TRIP;
        end else if (engaged) begin
          next_state = ST_RUN;
        end else if ({10'h000, secs} == inj_dur) begin
          next_state = ST_IDLE;
        end
      end
      ST_TRIP: begin
        if (i_trip_reset) begin
          next_state = ST_IDLE;
        end else if ((engaged || i_auto_restart_en)
                     && secs == RESTART_WAIT_S) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state    <= ST_IDLE;
      ovr_run  <= 1'b0;
      inch_run <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != ST_RUN) begin
        ovr_run  <= 1'b0;
        inch_run <= 1'b0;
      end else if (engaged) begin
        ovr_run  <= 1'b1;
        inch_run <= 1'b0;
      end else if (state != ST_RUN) begin
        inch_run <= inch_ok && !(i_enable_in && i_run_in);
      end
    end
  end

  // seconds timer restarts on every state change
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cyc  <= 32'h0000_0000;
      secs <= 6'h00;
    end else if (next_state != state) begin
      cyc  <= 32'h0000_0000;
      secs <= 6'h00;
    end else if (cyc == 32'(SECOND_CYCLES - 1)) begin
      cyc  <= 32'h0000_0000;
      secs <= secs + 6'h01;
    end else begin
      cyc <= cyc + 32'h0000_0001;
    end
  end

  // ramp rate is one speed unit per i_decel_cycles + 1 clocks
  always_comb begin
    next_speed = ZERO_SPEED;
    if (next_state == ST_RUN) begin
      next_speed = sel_speed;
    end else if (next_state == ST_RAMP) begin
      next_speed = o_speed;
      if (ramp_cnt >= i_decel_cycles && o_speed != ZERO_SPEED) begin
        next_speed = o_speed - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ramp_cnt <= 16'h0000;
    end else if (state != ST_RAMP || ramp_cnt >= i_decel_cycles) begin
      ramp_cnt <= 16'h0000;
    end else begin
      ramp_cnt <= ramp_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_speed        <= 16'h0000;
      o_forward      <= 1'b1;
      o_switching    <= 1'b0;
      o_inj_active   <= 1'b0;
      o_inj_strength <= 16'h0000;
      o_tripped      <= 1'b0;
      o_override_engaged <= 1'b0;
    end else begin
      o_speed     <= next_speed;
      o_forward   <= engaged || ovr_run || !i_reverse;
      o_switching <= (next_state == ST_RUN)
                     || (next_state == ST_RAMP);
      o_inj_active <= (next_state == ST_INJECT);
      o_inj_strength <= (next_state == ST_INJECT)
                        ? clamp_val(i_inj_strength, INJ_STRENGTH_MIN,
                                    INJ_STRENGTH_MAX)
                        : 16'h0000;
      o_tripped <= (next_state == ST_TRIP);
      o_override_engaged <= engaged;
    end
  end

  // ------------------------------------------------------------------
  // carrier and brake
  // ------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      carrier_idx <= CARRIER_IDX_MAX;
    end else if (i_heat_rise && carrier_idx != CARRIER_IDX_MIN) begin
      carrier_idx <= carrier_idx - 3'h1;
    end else if (i_heat_fall && carrier_idx != CARRIER_IDX_MAX) begin
      carrier_idx <= carrier_idx + 3'h1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_carrier_khz  <= 5'h10;
      o_brake_switch <= 1'b0;
    end else begin
      o_carrier_khz <= {(i_carrier_auto ? 4'(carrier_idx)
                                        : 4'(i_carrier_fixed))
                        + 4'h1, 1'b0};
      o_brake_switch <= i_brake_fitted && i_brake_enable
                        && i_regen;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  AST_OVR_FORWARD: assert property (engaged && !trip_now
    && state != ST_TRIP |=> o_forward && o_switching)
    else $error("override not forward");
  AST_INCH_INHIBIT: assert property (engaged |=> !inch_run)
    else $error("inch active during override");
  AST_THERMAL_MASKED: assert property (state == ST_RUN && engaged
    && !i_trip_other |=> state != ST_TRIP)
    else $error("thermal trip taken in override");
  AST_CODE_CHECK: assert property (i_override_enable_req
    && i_access_code != ACCESS_CODE |=> !$rose(o_override_enabled))
    else $error("override enabled with wrong code");
  AST_LAYOUT_LOCK: assert property (o_override_enabled
    && !i_override_disable_req |=> o_layout_building)
    else $error("layout left building services");
  AST_FREEWHEEL: assert property (state == ST_RUN && !engaged
    && !inch_run && stop_cmd && !trip_now
    && i_stop_mode == STOP_FREEWHEEL |=> !o_switching)
    else $error("switching after freewheel stop");
  AST_DEFLUX_FIRST: assert property ($rose(o_inj_active)
    |-> $past(state == ST_DEFLUX) && !o_switching)
    else $error("injection without deflux");
  AST_STRENGTH: assert property (o_inj_active |->
    o_inj_strength >= INJ_STRENGTH_MIN
    && o_inj_strength <= INJ_STRENGTH_MAX)
    else $error("injection strength out of range");
  AST_CARRIER: assert property (o_carrier_khz >= 5'h02
    && o_carrier_khz <= 5'h10 && !o_carrier_khz[0])
    else $error("carrier out of range");
  AST_BRAKE: assert property (i_brake_fitted && i_brake_enable
    && i_regen |=> o_brake_switch) else $error("brake not switched");
  AST_RAMP_DOWN: assert property (state == ST_RAMP
    && next_state == ST_RAMP |=> o_speed <= $past(o_speed))
    else $error("speed rose while ramping");

  COV_OVERRIDE_RUN: cover property (engaged ##1 o_switching);
  COV_INJECTION: cover property (state == ST_DEFLUX ##1
    state == ST_INJECT);
  COV_RETRY: cover property (state == ST_TRIP ##1 state == ST_IDLE);
  COV_RAMP_DONE: cover property (state == ST_RAMP ##1 state == ST_IDLE);

endmodule // drive_speed_stop_control

// ===== logic/drive_ctrl_pkg.sv
// constants and skip band and speed limit types for the drive speed and stop control
package drive_ctrl_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_FREQ_HZ       = 200_000_000;
  localparam int TICK_TIME_S       = 1;
  localparam int SECOND_CYCLES_DEF = CLK_FREQ_HZ * TICK_TIME_S;
  localparam logic [5:0] DEFLUX_TIME_S  = 6'h02;
  localparam logic [5:0] RESTART_WAIT_S = 6'h0a;

  // ------------------------------------------------------------------
  // widths and limits
  // ------------------------------------------------------------------
  localparam int SPEED_W    = 16;
  localparam int TIME_W     = 32;
  localparam int SKIP_COUNT = 4;
  localparam logic [15:0] INJ_STRENGTH_MIN = 16'h0001;
  localparam logic [15:0] INJ_STRENGTH_MAX = 16'h0064;
  localparam logic [15:0] INJ_DURATION_MIN = 16'h0001;
  localparam logic [15:0] INJ_DURATION_MAX = 16'h003c;
  localparam logic [15:0] ZERO_SPEED       = 16'h0000;
  // four bcd digits of the factory access code
  localparam logic [15:0] ACCESS_CODE      = 16'h1470;

  // ------------------------------------------------------------------
  // carrier: index 0..7 maps to 2..16 khz
  // ------------------------------------------------------------------
  localparam logic [2:0] CARRIER_IDX_MIN = 3'h0;
  localparam logic [2:0] CARRIER_IDX_MAX = 3'h7;

  // ------------------------------------------------------------------
  // stop mode codes
  // ------------------------------------------------------------------
  localparam logic [1:0] STOP_DECELERATE = 2'h0;
  localparam logic [1:0] STOP_FREEWHEEL  = 2'h1;
  localparam logic [1:0] STOP_INJECTION  = 2'h2;

  typedef struct packed {
    logic               enable;
    logic [SPEED_W-1:0] centre;
    logic [SPEED_W-1:0] width;
  } skip_band_type;

  typedef struct packed {
    logic [SPEED_W-1:0] min_freq;
    logic [SPEED_W-1:0] max_freq;
  } speed_limits_type;

endpackage

// ===== verification/operator_panel_model.sv
// operator panel model: access code entry and override request and stop
`timescale 1ns/1ps
module operator_panel_model (
  // clock, reset and command from the bench
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic [1:0]  i_cmd,
  input  wire logic [15:0] i_code,
  // lines towards the drive
  output logic             o_enable_req,
  output logic [15:0]      o_access_code,
  output logic             o_request,
  output logic             o_panel_stop
);
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_enable_req  <= 1'b0;
      o_access_code <= 16'h0000;
      o_request     <= 1'b0;
      o_panel_stop  <= 1'b0;
    end else begin
      // code moves with the pulse so the drive takes them as a pair
      o_enable_req  <= (i_cmd == 2'h1);
      o_access_code <= i_code;
      // cmd 2 presses stop while requesting; cmd 3 drops request, keeps stop
      o_request     <= (i_cmd == 2'h2);
      o_panel_stop  <= i_cmd[1];
    end
  end
endmodule // operator_panel_model

// ===== verification/tb_drive_speed_stop_control.sv
// self-checking bench for the drive speed and stop control
`timescale 1ns/1ps
module tb_drive_speed_stop_control;
  import drive_ctrl_pkg::*;
  logic i_ref_clk, i_nrst, i_reverse, i_inch_close, i_inch_src_analog;
  logic i_override_request, i_override_enable_req, i_override_disable_req;
  logic i_override_src_analog, i_layout_req, i_layout_req_industrial;
  logic i_defaults_restore, i_enable_in, i_run_in, i_panel_stop;
  logic i_trip_thermal, i_trip_other, i_i2t_excess, i_trip_reset;
  logic i_auto_restart_en, i_carrier_auto, i_heat_rise, i_heat_fall;
  logic i_brake_fitted, i_brake_enable, i_regen;
  logic [15:0] i_speed_ref, i_analog2, i_decel_cycles, i_inch_preset;
  logic [15:0] i_override_preset, i_access_code, i_inj_strength, code;
  logic [15:0] i_inj_duration_s, o_speed, o_inj_strength;
  logic [31:0] i_time_now, o_time_enabled, o_time_stressed;
  logic [2:0]  i_carrier_fixed;
  logic [1:0]  i_stop_mode, cmd;
  logic [4:0]  o_carrier_khz;
  logic o_forward, o_switching, o_inj_active, o_brake_switch, o_tripped;
  logic o_override_enabled, o_override_engaged, o_layout_building;
  logic o_code_rejected, o_stressed;
  speed_limits_type    i_limits;
  skip_band_type [3:0] i_skip;
  int error_cnt = 0, check_count = 0, cyc = 0;
  // request in, speed expected: band 25 +-5 on, band 40 off, 5..50
  logic [15:0] rows [7][2] = '{'{16'h0016, 16'h0014}, '{16'h0019, 16'h001e},
    '{16'h001c, 16'h001e}, '{16'h0013, 16'h0013}, '{16'h0028, 16'h0028},
    '{16'h0002, 16'h0005}, '{16'h0040, 16'h0032}};

  drive_speed_stop_control #(.SECOND_CYCLES(10)) i_dut (.i_ref_clk, .i_nrst,
    .i_limits, .i_skip, .i_speed_ref, .i_analog2, .i_decel_cycles,
    .i_reverse, .i_inch_close, .i_inch_src_analog, .i_inch_preset,
    .i_override_request, .i_override_enable_req, .i_override_disable_req,
    .i_access_code, .i_override_src_analog, .i_override_preset,
    .i_layout_req, .i_layout_req_industrial, .i_defaults_restore,
    .i_time_now, .i_enable_in, .i_run_in, .i_panel_stop, .i_stop_mode,
    .i_inj_strength, .i_inj_duration_s, .i_trip_thermal, .i_trip_other,
    .i_i2t_excess, .i_trip_reset, .i_auto_restart_en, .i_carrier_auto,
    .i_carrier_fixed, .i_heat_rise, .i_heat_fall, .i_brake_fitted,
    .i_brake_enable, .i_regen, .o_speed, .o_forward, .o_switching,
    .o_inj_active, .o_inj_strength, .o_carrier_khz, .o_brake_switch,
    .o_tripped, .o_override_enabled, .o_override_engaged, .o_layout_building,
    .o_code_rejected, .o_stressed, .o_time_enabled, .o_time_stressed);
  operator_panel_model i_panel (.i_ref_clk, .i_nrst, .i_cmd(cmd),
    .i_code(code), .o_enable_req(i_override_enable_req),
    .o_access_code(i_access_code), .o_request(i_override_request),
    .o_panel_stop(i_panel_stop));

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  // stimulus lasts about 330 cycles
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // sample away from the edge so registered outputs have settled
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  task automatic go();
    @(posedge i_ref_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  initial begin
    {i_reverse, i_inch_close, i_inch_src_analog, i_override_disable_req,
     i_override_src_analog, i_layout_req, i_layout_req_industrial,
     i_defaults_restore, i_enable_in, i_run_in, i_trip_thermal, i_trip_other,
     i_i2t_excess, i_trip_reset, i_auto_restart_en, i_heat_rise, i_heat_fall,
     i_brake_fitted, i_brake_enable, i_regen, i_speed_ref, i_analog2,
     i_decel_cycles, i_inch_preset, i_override_preset, i_inj_strength, code,
     i_inj_duration_s, i_time_now, i_carrier_fixed, i_stop_mode, cmd} = '0;
    i_carrier_auto = 1'b1;
    i_limits = '{16'h0005, 16'h0032};
    i_skip = '{'0, '0, '{1'b0, 16'h0028, 16'h0005}, '{1'b1, 16'h0019, 16'h0005}};
    i_nrst = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    step(1);
    chk(32'(o_carrier_khz), 32'h10);
    go();
    i_enable_in <= 1'b1;
    i_run_in <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      i_speed_ref <= rows[k][0];
      step(2);
      chk(32'(o_speed), 32'(rows[k][1]));
      go();
    end
    i_inch_close <= 1'b1;
    i_inch_src_analog <= 1'b1;
    i_analog2 <= 16'h0001;
    step(3);
    chk(32'(o_speed), 32'h05);
    go();
    i_inch_src_analog <= 1'b0;
    i_inch_preset <= 16'h000a;
    i_override_preset <= 16'h0023;
    i_reverse <= 1'b1;
    i_time_now <= 32'h1234;
    code <= 16'h1471;
    cmd <= 2'h1;
    step(3);
    chk(32'(o_speed), 32'h0a);
    chk(32'(o_code_rejected), 32'h1);
    chk(32'(o_override_enabled), 32'h0);
    go();
    code <= 16'h1470;
    step(4);
    chk(32'(o_override_enabled), 32'h1);
    chk(o_time_enabled, 32'h1234);
    go();
    cmd <= 2'h2;
    i_layout_req <= 1'b1;
    i_layout_req_industrial <= 1'b1;
    i_defaults_restore <= 1'b1;
    go();
    i_trip_thermal <= 1'b1;
    i_defaults_restore <= 1'b0;
    step(4);
    chk({o_override_engaged, o_forward, o_switching, o_tripped}, 32'he);
    chk(32'(o_speed), 32'h23);
    chk({o_stressed, o_layout_building, o_override_enabled}, 32'h7);
    chk(o_time_stressed, 32'h1234);
    go();
    {i_trip_thermal, i_inch_close} <= 2'h0;
    i_stop_mode <= 2'h1;
    cmd <= 2'h3;
    step(3);
    chk(32'(o_switching), 32'h0);
    go();
    {cmd, i_inch_close, i_reverse, i_layout_req} <= '0;
    {i_stop_mode, i_inj_strength, i_inj_duration_s} <= {2'h2, 16'hc8, 16'h1};
    repeat (4) go();
    i_run_in <= 1'b0;
    step(2);
    chk({o_switching, o_inj_active}, 32'h0);
    step(20);
    chk({o_inj_active, o_inj_strength}, 32'h10064);
    step(12);
    chk(32'(o_inj_active), 32'h0);
    go();
    {i_stop_mode, i_decel_cycles, i_run_in} <= {2'h0, 16'h1, 1'b1};
    repeat (4) go();
    i_run_in <= 1'b0;
    step(4);
    chk(32'(o_switching), 32'h1);
    step(110);
    chk({o_switching, o_speed}, 32'h0);
    go();
    i_heat_rise <= 1'b1;
    {i_brake_fitted, i_brake_enable, i_regen} <= 3'h7;
    go();
    i_heat_rise <= 1'b0;
    step(2);
    chk({o_carrier_khz, o_brake_switch}, 32'h1d);
    go();
    {i_carrier_auto, i_brake_enable} <= 2'h0;
    step(2);
    chk({o_carrier_khz, o_brake_switch}, 32'h04);
    go();
    {i_auto_restart_en, i_run_in, i_trip_other} <= 3'h7;
    go();
    i_trip_other <= 1'b0;
    step(60);
    chk(32'(o_tripped), 32'h1);
    step(50);
    chk(32'(o_tripped), 32'h0);
    go();
    i_trip_other <= 1'b1;
    go();
    {i_trip_other, i_trip_reset} <= 2'h1;
    step(2);
    chk(32'(o_tripped), 32'h0);
    report_and_stop();
  end
endmodule // tb_drive_speed_stop_control
